// ---- rtl/strobe_phase_shift_dll_control.v ----
// strobe phase-shift loop controller with apb register access
`timescale 1ns/1ps
`include "strobe_dll_consts.vh"
// Behaviour
// - shift read strobes used as incoming clocks
// - loops shared; per-side offset trims setting
// - each pin picks one of two settings
// - all pins take new settings together
// - loop setting word is Gray-coded
// - lock within 1280 or 256 reference cycles
// - below 100 MHz clamp delay to 2.5 ns
// - two or four loops, one frequency each
// - each loop has two outputs, one with offset
// - two loops reach top, bottom, right
// - four loops reach two adjacent sides
// - bank pins use either or both loops
// - one loop serves both adjacent sides
// - reference from pll or dedicated pin
// - reference through chain, phase compared
// - comparator steps 6-bit Gray setting counter
module strobe_phase_shift_dll_control #(
  parameter NL = 4,
  parameter NP = 4,
  parameter [5:0] SLOW_MAX_SETTING = 6'h0f
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire [NL-1:0] ref_pll,
  input wire [NL*4-1:0] ref_pin,
  input wire [NL-1:0] cmp_late,
  output reg [NL*6-1:0] loop_gray,
  output reg [NL*5-1:0] chain_taps,
  output reg [NL-1:0] loop_locked,
  output reg [4*NP*6-1:0] pin_delay
);
  localparam SW = NL * 6;

  // ****************************************
  // registers
  // ****************************************
  reg [2:0] ctrl_q;
  reg [11:0] ref_sel_q;
  reg [31:0] loop_ofs_q;
  reg [31:0] side_ofs_q;
  reg [31:0] slot_sel_q;
  reg [15:0] pin_sel_q;
  reg [SW-1:0] sync1_q;
  reg [SW-1:0] sync2_q;
  reg [NL-1:0] ref_q;
  reg [SW-1:0] bin_q;
  reg [NL*11-1:0] cnt_q;
  wire [NL-1:0] ref_edge;
  wire enable;
  wire low_jitter;
  wire slow;
  wire [10:0] lock_target;
  wire wr_en;
  wire rd_setup;
  wire update;
  reg [31:0] rdata_d;
  reg addr_ok;
  reg [4*2*6-1:0] slot_val;
  integer s;
  integer k;
  integer j;

  assign enable = ctrl_q[`CTRL_ENABLE];
  assign low_jitter = ctrl_q[`CTRL_LOW_JITTER];
  assign slow = ctrl_q[`CTRL_SLOW];
  assign lock_target = low_jitter ? `LOCK_REF_CYCLES_LJ : `LOCK_REF_CYCLES_STD;
  assign update = |ref_edge;

  // ****************************************
  // helpers
  // ****************************************
  // which loop can reach which side (0 left, 1 bottom, 2 right, 3 top)
  function reach;
    input [1:0] l;
    input [1:0] sd;
    begin
      if (NL == 2)
        reach = (l < 2'd2) && (sd != 2'd0);
      else
      begin
        case (l)
          2'd0: reach = (sd == 2'd3) || (sd == 2'd0);
          2'd1: reach = (sd == 2'd0) || (sd == 2'd1);
          2'd2: reach = (sd == 2'd1) || (sd == 2'd2);
          default: reach = (sd == 2'd2) || (sd == 2'd3);
        endcase
      end
    end
  endfunction

  // base plus two signed trims, saturated, clamped in slow mode
  function [5:0] trim;
    input [5:0] base;
    input [5:0] o1;
    input [5:0] o2;
    input slw;
    reg signed [8:0] t;
    begin
      t = $signed({3'b000, base}) + $signed({{3{o1[5]}}, o1}) + $signed({{3{o2[5]}}, o2});
      if (t < 0)
        trim = 6'h00;
      else if (t > 9'sd63)
        trim = 6'h3f;
      else
        trim = t[5:0];
      if (slw && (trim > SLOW_MAX_SETTING))
        trim = SLOW_MAX_SETTING;
    end
  endfunction

  function [5:0] to_gray;
    input [5:0] b;
    begin
      to_gray = b ^ {1'b0, b[5:1]};
    end
  endfunction

  // ****************************************
  // apb slave
  // ****************************************
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  always @*
  begin
    rdata_d = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr == `OFS_CTRL)
      rdata_d = {29'h0, ctrl_q};
    else if (paddr == `OFS_REF_SEL)
      rdata_d = {20'h00000, ref_sel_q};
    else if (paddr == `OFS_STATUS)
      rdata_d[NL-1:0] = loop_locked;
    else if (paddr == `OFS_LOOP_OFS)
      rdata_d = loop_ofs_q;
    else if (paddr == `OFS_SIDE_OFS)
      rdata_d = side_ofs_q;
    else if (paddr == `OFS_SLOT_SEL)
      rdata_d = slot_sel_q;
    else if (paddr == `OFS_PIN_SEL)
      rdata_d = {16'h0000, pin_sel_q};
    else if (paddr == `OFS_SETTING)
    begin
      for (j = 0; j < NL; j = j + 1)
        rdata_d[j*8 +: 6] = loop_gray[j*6 +: 6];
    end
    else
      addr_ok = 1'b0;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `RST_CTRL;
      ref_sel_q <= `RST_REF_SEL;
      loop_ofs_q <= `RST_LOOP_OFS;
      side_ofs_q <= `RST_SIDE_OFS;
      slot_sel_q <= `RST_SLOT_SEL;
      pin_sel_q <= `RST_PIN_SEL;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      if (rd_setup)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_d;
        pslverr <= !addr_ok;
      end
      if (wr_en)
      begin
        if (paddr == `OFS_CTRL)
          ctrl_q <= pwdata[2:0];
        else if (paddr == `OFS_REF_SEL)
          ref_sel_q <= pwdata[11:0];
        else if (paddr == `OFS_LOOP_OFS)
          loop_ofs_q <= pwdata;
        else if (paddr == `OFS_SIDE_OFS)
          side_ofs_q <= pwdata;
        else if (paddr == `OFS_SLOT_SEL)
          slot_sel_q <= pwdata;
        else if (paddr == `OFS_PIN_SEL)
          pin_sel_q <= pwdata[15:0];
      end
    end
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= {SW{1'b0}};
      sync2_q <= {SW{1'b0}};
    end
    else
    begin
      sync1_q <= {cmp_late, ref_pin, ref_pll};
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // per-loop setting counter and lock
  // ****************************************
  genvar l;
  generate
    for (l = 0; l < NL; l = l + 1)
    begin : g_loop
      wire [2:0] sel;
      wire ref_now;
      wire late;
      wire [5:0] bin;
      wire [10:0] cnt;
      reg [5:0] nb;
      assign sel = ref_sel_q[l*3 +: 3];
      assign ref_now = sel[`REF_SEL_PIN] ? sync2_q[NL + l*4 + sel[1:0]] : sync2_q[l];
      assign late = sync2_q[NL*5 + l];
      assign ref_edge[l] = ref_now && !ref_q[l] && enable;
      assign bin = bin_q[l*6 +: 6];
      assign cnt = cnt_q[l*11 +: 11];

      // chain too long steps down, too short steps up
      always @*
      begin
        nb = bin;
        if (late && (bin != 6'h00))
          nb = bin - 6'd1;
        else if (!late && (bin != 6'h3f))
          nb = bin + 6'd1;
      end

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ref_q[l] <= 1'b0;
          bin_q[l*6 +: 6] <= 6'h00;
          cnt_q[l*11 +: 11] <= 11'd0;
          loop_locked[l] <= 1'b0;
          loop_gray[l*6 +: 6] <= 6'h00;
          chain_taps[l*5 +: 5] <= 5'd1;
        end
        else
        begin
          ref_q[l] <= ref_now;
          if (!enable)
          begin
            cnt_q[l*11 +: 11] <= 11'd0;
            loop_locked[l] <= 1'b0;
          end
          else if (ref_edge[l])
          begin
            bin_q[l*6 +: 6] <= nb;
            loop_gray[l*6 +: 6] <= to_gray(nb);
            chain_taps[l*5 +: 5] <= {1'b0, nb[5:2]} + 5'd1;
            if (cnt < lock_target)
              cnt_q[l*11 +: 11] <= cnt + 11'd1;
            if (cnt + 11'd1 >= lock_target)
              loop_locked[l] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // per-side slot settings
  // ****************************************
  // each side has two slots, each from a reaching loop and output
  always @*
  begin
    slot_val = {48{1'b0}};
    for (s = 0; s < 4; s = s + 1)
    begin
      for (k = 0; k < 2; k = k + 1)
      begin
        if (reach(slot_sel_q[s*8 + k*4 +: 2], s[1:0]) && (slot_sel_q[s*8 + k*4 +: 2] < NL))
          slot_val[(s*2 + k)*6 +: 6] = trim(bin_q[slot_sel_q[s*8 + k*4 +: 2]*6 +: 6],
            slot_sel_q[s*8 + k*4 + `SLOT_OUT] ? loop_ofs_q[slot_sel_q[s*8 + k*4 +: 2]*8 +: 6] : 6'h00,
            side_ofs_q[s*8 +: 6], slow);
      end
    end
  end

  // ****************************************
  // strobe pin delay words
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < 4 * NP; p = p + 1)
    begin : g_pin
      wire [5:0] pick;
      assign pick = slot_val[((p / NP) * 2 + pin_sel_q[p]) * 6 +: 6];
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          pin_delay[p*6 +: 6] <= 6'h00;
        else if (update)
          pin_delay[p*6 +: 6] <= to_gray(pick);
      end
    end
  endgenerate
endmodule // strobe_phase_shift_dll_control

// ---- rtl/strobe_dll_consts.vh ----
// constants for the strobe phase-shift loop controller
`ifndef STROBE_DLL_CONSTS_VH
`define STROBE_DLL_CONSTS_VH
// ****************************************
// register byte offsets
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_REF_SEL 8'h04
`define OFS_STATUS 8'h08
`define OFS_LOOP_OFS 8'h0c
`define OFS_SIDE_OFS 8'h10
`define OFS_SLOT_SEL 8'h14
`define OFS_PIN_SEL 8'h18
`define OFS_SETTING 8'h1c
// ****************************************
// field positions
// ****************************************
`define CTRL_ENABLE 0
`define CTRL_LOW_JITTER 1
`define CTRL_SLOW 2
`define REF_SEL_PIN 2
`define SLOT_OUT 2
// ****************************************
// reset values
// ****************************************
`define RST_CTRL 3'h0
`define RST_REF_SEL 12'h000
`define RST_LOOP_OFS 32'h0000_0000
`define RST_SIDE_OFS 32'h0000_0000
`define RST_SLOT_SEL 32'h0000_0000
`define RST_PIN_SEL 16'h0000
// ****************************************
// timing counts, lock in reference cycles, slow delay in ps
// ****************************************
`define LOCK_REF_CYCLES_LJ 11'd1280
`define LOCK_REF_CYCLES_STD 11'd256
`define STROBE_SLOW_MAX_PS 2500
`define CHAIN_ELEMENTS 16
`endif

// ---- verif/strobe_dll_monitor.sv ----
// assertions for the strobe loop controller
`timescale 1ns/1ps
module strobe_dll_monitor #(
  parameter NL = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire [NL*6-1:0] loop_gray,
  input wire [NL*5-1:0] chain_taps,
  input wire [NL-1:0] loop_locked
);
  function automatic [5:0] g2b(input [5:0] g);
    g2b = g ^ (g >> 1) ^ (g >> 2) ^ (g >> 3) ^ (g >> 4) ^ (g >> 5);
  endfunction
  reg [11:0] cyc_q;
  wire [5:0] bin0 = g2b(loop_gray[5:0]);
  // pclk cycles since reset, saturating
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cyc_q <= 12'h000;
    else if (cyc_q != 12'hfff)
      cyc_q <= cyc_q + 12'h001;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad_rd;
    s_setup ##0 (!pwrite && (paddr > 8'h1c || paddr[1:0] != 2'h0));
  endsequence
  property p_ready;
    pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err;
    s_bad_rd |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_err: assert property (p_err) else $error("unmapped read not refused");
  property p_ok;
    s_setup ##0 (paddr <= 8'h1c && paddr[1:0] == 2'h0) |=> !pslverr;
  endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_hold;
    psel && penable |=> $stable(prdata) && $stable(pslverr);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_gray;
    $countones(loop_gray[5:0] ^ $past(loop_gray[5:0])) <= 1;
  endproperty
  a_gray: assert property (p_gray) else $error("setting moved by more than one bit");
  property p_taps;
    chain_taps[4:0] == {1'b0, bin0[5:2]} + 5'h01;
  endproperty
  a_taps: assert property (p_taps) else $error("chain length off setting");
  property p_lock;
    $rose(loop_locked[0]) |-> cyc_q >= 12'd1536;
  endproperty
  a_lock: assert property (p_lock) else $error("lock too early");
  property p_keep;
    $fell(loop_locked[0]) |-> $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2);
  endproperty
  a_keep: assert property (p_keep) else $error("lock dropped");
endmodule // strobe_dll_monitor

bind strobe_phase_shift_dll_control strobe_dll_monitor #(.NL(NL)) mon_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .loop_gray(loop_gray), .chain_taps(chain_taps), .loop_locked(loop_locked));

// ---- verif/ref_source.sv ----
// reference clock source, still while not running
`timescale 1ns/1ps
module ref_source #(
  parameter int HALF_NS = 80
) (
  input wire logic run,
  output logic clk_o
);
  initial
  begin
    clk_o = 1'b0;
    #7;
    forever
    begin
      #(HALF_NS);
      clk_o = run ? ~clk_o : 1'b0;
    end
  end
endmodule // ref_source

// ---- verif/tb_top.sv ----
// self-checking bench for the strobe loop controller
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] cmp_late = 4'ha;
  logic run = 1'b0;
  logic [31:0] q;
  logic e;
  wire ref_clk;
  wire pready;
  wire [31:0] prdata;
  wire pslverr;
  wire [23:0] loop_gray;
  wire [19:0] chain_taps;
  wire [3:0] loop_locked;
  wire [95:0] pin_delay;
  int checks = 0;
  int fail_count = 0;
  int edges = 0;
  row_t rows [8];
  always #10 pclk = ~pclk;
  always @(posedge ref_clk) edges++;
  ref_source ref_u (.run(run), .clk_o(ref_clk));
  strobe_phase_shift_dll_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ref_pll({4{ref_clk}}), .ref_pin({4{ref_clk, 3'b000}}), .cmp_late(cmp_late), .loop_gray(loop_gray),
    .chain_taps(chain_taps), .loop_locked(loop_locked), .pin_delay(pin_delay));
  // ****
  // tasks
  // ****
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq, output logic re);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      $display("Error %s expected %h seen %h", n, x, g);
      fail_count++;
    end
  endtask
  task ctrl(input logic [31:0] v);
    apb(1'b1, 8'h00, v, q, e);
    edges = 0;
    run <= 1'b1;
  endtask
  task status(input logic [31:0] x);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk("status", x, q);
  endtask
  task go(input int n);
    while (edges < n) @(posedge pclk);
    repeat (8) @(posedge pclk);
  endtask
  task results;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial
  begin
    rows = '{'{8'h04, 32'h0000_0fff, 32'h0000_0fff, 1'b0}, '{8'h0c, 32'h3f2a_1501, 32'h3f2a_1501, 1'b0},
      '{8'h10, 32'h0102_0304, 32'h0102_0304, 1'b0}, '{8'h14, 32'h7654_3210, 32'h7654_3210, 1'b0},
      '{8'h18, 32'h0000_a5a5, 32'h0000_a5a5, 1'b0}, '{8'h08, 32'hffff_ffff, 32'h0000_0000, 1'b0},
      '{8'h1c, 32'hffff_ffff, 32'h0000_0000, 1'b0}, '{8'h24, 32'h0000_0001, 32'h0000_0000, 1'b1}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk("ctrl reset", 32'h0, q);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].w, q, e);
      chk("write err", {31'h0, rows[i].e}, {31'h0, e});
      apb(1'b0, rows[i].a, 32'h0, q, e);
      chk("read data", rows[i].r, q);
      chk("read err", {31'h0, rows[i].e}, {31'h0, e});
    end
    apb(1'b1, 8'h04, 32'h0000_09c0, q, e);
    apb(1'b1, 8'h0c, 32'h003f_0000, q, e);
    apb(1'b1, 8'h10, 32'h003e_0000, q, e);
    apb(1'b1, 8'h14, 32'h0062_0202, q, e);
    apb(1'b1, 8'h18, 32'h0000_0200, q, e);
    ctrl(32'h1);
    go(250);
    status(32'h0);
    go(260);
    status(32'h7);
    chk("loop2", 32'h20, {26'h0, loop_gray[12+:6]});
    chk("taps2", 32'h10, {27'h0, chain_taps[10+:5]});
    chk("pin4", 32'h20, {26'h0, pin_delay[24+:6]});
    chk("pin8", 32'h23, {26'h0, pin_delay[48+:6]});
    chk("pin9", 32'h22, {26'h0, pin_delay[54+:6]});
    chk("pin0", 32'h00, {26'h0, pin_delay[0+:6]});
    ctrl(32'h5);
    go(3);
    chk("pin8 slow", 32'h08, {26'h0, pin_delay[48+:6]});
    status(32'h7);
    ctrl(32'h0);
    status(32'h0);
    ctrl(32'h3);
    go(1270);
    status(32'h0);
    go(1285);
    status(32'h7);
    results;
  end
  initial
  begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    results;
  end
endmodule // tb_top
